// [verilog/gpx_pkg.sv]
// Purpose: Shared constants and types for the two-port GPIO expander register map
// Assumes: Byte-wide registers selected by an 8-bit pointer
// Notes: Pointer values, reset values and link framing constants live here
package gpx_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register pointer values
    localparam logic [7:0] PTR_IN0 = 8'h00;
    localparam logic [7:0] PTR_IN1 = 8'h01;
    localparam logic [7:0] PTR_OUT0 = 8'h02;
    localparam logic [7:0] PTR_OUT1 = 8'h03;
    localparam logic [7:0] PTR_INV0 = 8'h04;
    localparam logic [7:0] PTR_INV1 = 8'h05;
    localparam logic [7:0] PTR_DIR0 = 8'h06;
    localparam logic [7:0] PTR_DIR1 = 8'h07;
    localparam logic [7:0] PTR_DRV0L = 8'h40;
    localparam logic [7:0] PTR_DRV0H = 8'h41;
    localparam logic [7:0] PTR_DRV1L = 8'h42;
    localparam logic [7:0] PTR_DRV1H = 8'h43;
    localparam logic [7:0] PTR_LAT0 = 8'h44;
    localparam logic [7:0] PTR_LAT1 = 8'h45;
    localparam logic [7:0] PTR_PEN0 = 8'h46;
    localparam logic [7:0] PTR_PEN1 = 8'h47;
    localparam logic [7:0] PTR_PSEL0 = 8'h48;
    localparam logic [7:0] PTR_PSEL1 = 8'h49;
    localparam logic [7:0] PTR_MASK0 = 8'h4A;
    localparam logic [7:0] PTR_MASK1 = 8'h4B;
    localparam logic [7:0] PTR_IRQ0 = 8'h4C;
    localparam logic [7:0] PTR_IRQ1 = 8'h4D;
    localparam logic [7:0] PTR_OCFG = 8'h4F;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and fixed answers
    localparam logic [7:0] RST_ONES = 8'hFF;
    localparam logic [7:0] RST_ZEROS = 8'h00;
    localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Link framing
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_STEP = 4'h1;
    // Arbitrary upper address bits
    localparam logic [3:0] ADDR_HIGH_DEFAULT = 4'h4;

    typedef enum logic [2:0] {
        ST_ADDR = 3'h0,
        ST_CMD = 3'h1,
        ST_WRITE = 3'h3,
        ST_READ = 3'h2,
        ST_IGNORE = 3'h6
    } gpx_state_t;

endpackage

// [verilog/gpx_regmap.sv]
// Purpose: Two-port GPIO expander register map behind a serial slave link
// Assumes: SCL high time well above four CLK periods; address pins static
// Notes: Link logic runs on SCL; register file and pins run on CLK
`timescale 1ns/1ns

// How it works
// - Byte after an acked write address loads the pointer; bit 6 reaches extended registers
// - Two read-only input level registers, pointers 00h and 01h
// - Input register bits show the pin level whatever the direction
// - Writes to input level registers change nothing
// - Input level registers have no reset value; they follow the pins
// - Output level registers at 02h and 03h, read/write, reset to all ones
// - Output bits do not affect pins configured as inputs
// - Reading an output level register returns the stored value
// - Invert registers at 04h and 05h, read/write, reset to zero
// - Direction registers at 06h and 07h, read/write, reset to all ones
// - Four drive strength registers 40h to 43h, reset to all ones
// - Latch enable registers 44h and 45h, reset to zero
// - Pull enable registers 46h and 47h, reset to zero
// - Pull select registers 48h and 49h, reset to all ones
// - Interrupt mask registers 4Ah and 4Bh, reset to all ones
// - Interrupt flag registers 4Ch and 4Dh, read-only, reset to zero
// - Output mode register 4Fh, read/write, reset to zero
// - Direction bit 1 makes an input, 0 makes an output
// - Invert bit 1 flips the reported input level
module gpx_regmap #(
    parameter logic [3:0] ADDR_HIGH = gpx_pkg::ADDR_HIGH_DEFAULT
) (
    // System
    input wire logic CLK,
    input wire logic SYS_RST,
    // Serial link
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [2:0] ADDR_PIN,
    // GPIO pins
    input wire logic [15:0] PIN_IN,
    output logic [15:0] PIN_OUT,
    output logic [15:0] PIN_OE,
    output logic [15:0] PULL_EN,
    output logic [15:0] PULL_UP
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    gpx_pkg::gpx_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift, tx, link_ptr, wr_byte, rx_byte;
    logic ack_pending, send, addr_hit;
    logic wr_tgl, rd_tgl;
    logic [2:0] addr_m, addr_s;
    logic link_clr, link_rst;
    logic [6:0] dev_addr;
    logic scl_m, scl_s, sda_m, sda_s, sda_d;
    logic wr_m, wr_s, wr_d, rd_m, rd_s, rd_d;
    logic wr_pulse, rd_pulse;
    logic [15:0] pin_m, pin_s;
    logic [7:0] rd_byte;
    logic [1:0][7:0] out_lvl, invert, dir;
    logic [3:0][7:0] drive;
    logic [1:0][7:0] latch_en, pull_en, pull_sel, mask;
    logic [7:0] out_cfg;
    logic [151:0] all_regs;

    assign link_rst = SYS_RST | link_clr;
    assign rx_byte = {shift[6:0], SDA_IN};
    assign dev_addr = {ADDR_HIGH, addr_s};
    assign addr_hit = (rx_byte[7:1] == dev_addr);
    assign wr_pulse = wr_s ^ wr_d;
    assign rd_pulse = rd_s ^ rd_d;
    assign all_regs = {out_lvl, invert, dir, drive, latch_en, pull_en, pull_sel, mask, out_cfg};

    ////////////////////////////////////////////////////////////////////////////////
    // Frame detection on CLK; SCL stands still between frames
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= SCL;
            scl_s <= scl_m;
            sda_m <= SDA_IN;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // Holds link logic cleared from start or stop until SCL falls
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            link_clr <= 1'b1;
        end else if (scl_s && (sda_d != sda_s)) begin
            link_clr <= 1'b1;
        end else if (!scl_s) begin
            link_clr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link bit engine, sampled on rising SCL
    always_ff @(posedge SCL or posedge link_rst) begin
        if (link_rst) begin
            state <= gpx_pkg::ST_ADDR;
            bit_cnt <= gpx_pkg::BIT_FIRST;
            shift <= gpx_pkg::RST_ZEROS;
            ack_pending <= 1'b0;
            send <= 1'b0;
        end else if (bit_cnt == gpx_pkg::BIT_ACK) begin
            bit_cnt <= gpx_pkg::BIT_FIRST;
            ack_pending <= 1'b0;
            // Master ack keeps the read going; our own address ack starts it
            send <= (state == gpx_pkg::ST_READ) && !SDA_IN;
        end else begin
            bit_cnt <= bit_cnt + gpx_pkg::BIT_STEP;
            shift <= rx_byte;
            if (bit_cnt == gpx_pkg::BIT_LAST) begin
                case (state)
                    gpx_pkg::ST_ADDR: begin
                        if (addr_hit) begin
                            ack_pending <= 1'b1;
                            state <= rx_byte[0] ? gpx_pkg::ST_READ : gpx_pkg::ST_CMD;
                        end else begin
                            state <= gpx_pkg::ST_IGNORE;
                        end
                    end
                    gpx_pkg::ST_CMD: begin
                        ack_pending <= 1'b1;
                        state <= gpx_pkg::ST_WRITE;
                    end
                    gpx_pkg::ST_WRITE: begin
                        ack_pending <= 1'b1;
                    end
                    default: begin
                        ack_pending <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Pointer and crossing requests survive repeated starts
    always_ff @(posedge SCL or posedge SYS_RST) begin
        if (SYS_RST) begin
            link_ptr <= gpx_pkg::RST_ZEROS;
            wr_byte <= gpx_pkg::RST_ZEROS;
            wr_tgl <= 1'b0;
            rd_tgl <= 1'b0;
            addr_m <= '0;
            addr_s <= '0;
        end else begin
            addr_m <= ADDR_PIN;
            addr_s <= addr_m;
            if (bit_cnt == gpx_pkg::BIT_LAST && state == gpx_pkg::ST_CMD) begin
                link_ptr <= rx_byte;
            end
            if (bit_cnt == gpx_pkg::BIT_LAST && state == gpx_pkg::ST_WRITE) begin
                wr_byte <= rx_byte;
                wr_tgl <= ~wr_tgl;
            end
            // Requested a bit early so the answer settles before it is shifted out
            if (bit_cnt == gpx_pkg::BIT_LAST && (state == gpx_pkg::ST_READ
                    || (state == gpx_pkg::ST_ADDR && addr_hit && rx_byte[0]))) begin
                rd_tgl <= ~rd_tgl;
            end
        end
    end

    // Data line driven on falling SCL
    always_ff @(negedge SCL or posedge link_rst) begin
        if (link_rst) begin
            SDA_OE <= 1'b0;
            SDA_OUT <= 1'b0;
            tx <= gpx_pkg::RST_ZEROS;
        end else begin
            SDA_OUT <= 1'b0;
            if (bit_cnt == gpx_pkg::BIT_ACK) begin
                SDA_OE <= ack_pending;
            end else if (send && bit_cnt == gpx_pkg::BIT_FIRST) begin
                SDA_OE <= ~rd_byte[7];
                tx <= {rd_byte[6:0], 1'b0};
            end else if (send) begin
                SDA_OE <= ~tx[7];
                tx <= {tx[6:0], 1'b0};
            end else begin
                SDA_OE <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crossing into CLK and pin sampling
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wr_m <= 1'b0;
            wr_s <= 1'b0;
            wr_d <= 1'b0;
            rd_m <= 1'b0;
            rd_s <= 1'b0;
            rd_d <= 1'b0;
        end else begin
            wr_m <= wr_tgl;
            wr_s <= wr_m;
            wr_d <= wr_s;
            rd_m <= rd_tgl;
            rd_s <= rd_m;
            rd_d <= rd_s;
        end
    end

    // No reset: levels follow the pins from power-up
    always_ff @(posedge CLK) begin
        pin_m <= PIN_IN;
        pin_s <= pin_m;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file
    function automatic logic writable(input logic [7:0] p);
        writable = (p >= gpx_pkg::PTR_OUT0 && p <= gpx_pkg::PTR_DIR1)
            || (p >= gpx_pkg::PTR_DRV0L && p <= gpx_pkg::PTR_MASK1)
            || (p == gpx_pkg::PTR_OCFG);
    endfunction

    // Pointer and data are held on the SCL side while the toggle crosses
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_lvl <= {2{gpx_pkg::RST_ONES}};
            invert <= {2{gpx_pkg::RST_ZEROS}};
            dir <= {2{gpx_pkg::RST_ONES}};
            drive <= {4{gpx_pkg::RST_ONES}};
            latch_en <= {2{gpx_pkg::RST_ZEROS}};
            pull_en <= {2{gpx_pkg::RST_ZEROS}};
            pull_sel <= {2{gpx_pkg::RST_ONES}};
            mask <= {2{gpx_pkg::RST_ONES}};
            out_cfg <= gpx_pkg::RST_ZEROS;
        end else if (wr_pulse) begin
            // Input and flag pointers fall through untouched
            if (link_ptr == gpx_pkg::PTR_OUT0) begin
                out_lvl[0] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_OUT1) begin
                out_lvl[1] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_INV0) begin
                invert[0] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_INV1) begin
                invert[1] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_DIR0) begin
                dir[0] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_DIR1) begin
                dir[1] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_DRV0L) begin
                drive[0] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_DRV0H) begin
                drive[1] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_DRV1L) begin
                drive[2] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_DRV1H) begin
                drive[3] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_LAT0) begin
                latch_en[0] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_LAT1) begin
                latch_en[1] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_PEN0) begin
                pull_en[0] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_PEN1) begin
                pull_en[1] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_PSEL0) begin
                pull_sel[0] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_PSEL1) begin
                pull_sel[1] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_MASK0) begin
                mask[0] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_MASK1) begin
                mask[1] <= wr_byte;
            end else if (link_ptr == gpx_pkg::PTR_OCFG) begin
                out_cfg <= wr_byte;
            end
        end
    end

    function automatic logic [7:0] read_reg(input logic [7:0] p);
        logic [15:0] level;
        level = pin_s ^ {invert[1], invert[0]};
        if (p == gpx_pkg::PTR_IN0) begin
            read_reg = level[7:0];
        end else if (p == gpx_pkg::PTR_IN1) begin
            read_reg = level[15:8];
        end else if (p == gpx_pkg::PTR_OUT0 || p == gpx_pkg::PTR_OUT1) begin
            read_reg = out_lvl[p[0]];
        end else if (p == gpx_pkg::PTR_INV0 || p == gpx_pkg::PTR_INV1) begin
            read_reg = invert[p[0]];
        end else if (p == gpx_pkg::PTR_DIR0 || p == gpx_pkg::PTR_DIR1) begin
            read_reg = dir[p[0]];
        end else if (p >= gpx_pkg::PTR_DRV0L && p <= gpx_pkg::PTR_DRV1H) begin
            read_reg = drive[p[1:0]];
        end else if (p == gpx_pkg::PTR_LAT0 || p == gpx_pkg::PTR_LAT1) begin
            read_reg = latch_en[p[0]];
        end else if (p == gpx_pkg::PTR_PEN0 || p == gpx_pkg::PTR_PEN1) begin
            read_reg = pull_en[p[0]];
        end else if (p == gpx_pkg::PTR_PSEL0 || p == gpx_pkg::PTR_PSEL1) begin
            read_reg = pull_sel[p[0]];
        end else if (p == gpx_pkg::PTR_MASK0 || p == gpx_pkg::PTR_MASK1) begin
            read_reg = mask[p[0]];
        end else if (p == gpx_pkg::PTR_IRQ0 || p == gpx_pkg::PTR_IRQ1) begin
            read_reg = gpx_pkg::IRQ_FLAGS_RST;
        end else if (p == gpx_pkg::PTR_OCFG) begin
            read_reg = out_cfg;
        end else begin
            read_reg = gpx_pkg::UNMAPPED_READ;
        end
    endfunction

    // Snapshot held until the next request, so the SCL side shifts a still word
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_byte <= gpx_pkg::RST_ZEROS;
        end else if (rd_pulse) begin
            rd_byte <= read_reg(link_ptr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PIN_OUT <= '0;
            PIN_OE <= '0;
            PULL_EN <= '0;
            PULL_UP <= '1;
        end else begin
            PIN_OE <= ~dir;
            PIN_OUT <= out_lvl & ~dir;
            PULL_EN <= pull_en;
            PULL_UP <= pull_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    a_input_readonly: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_pulse && (link_ptr == gpx_pkg::PTR_IN0 || link_ptr == gpx_pkg::PTR_IN1)
            |=> $stable(all_regs))
        else $error("Write to input level register changed state");

    a_unmapped_write: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_pulse && !writable(link_ptr) |=> $stable(all_regs))
        else $error("Write to unmapped pointer changed state");

    a_input_read: assert property (@(posedge CLK) disable iff (SYS_RST)
        rd_pulse && link_ptr == gpx_pkg::PTR_IN1
            |=> rd_byte == ($past(pin_s[15:8]) ^ $past(invert[1])))
        else $error("Input level read does not match pin and invert");

    a_output_read: assert property (@(posedge CLK) disable iff (SYS_RST)
        rd_pulse && link_ptr == gpx_pkg::PTR_OUT0 |=> rd_byte == $past(out_lvl[0]))
        else $error("Output level read does not return stored value");

    a_dir_write: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_pulse && link_ptr == gpx_pkg::PTR_DIR1 |=> dir[1] == $past(wr_byte))
        else $error("Direction write not stored");

    a_dir_drives: assert property (@(posedge CLK) disable iff (SYS_RST)
        !wr_pulse ##1 !wr_pulse |=> PIN_OE == ~$past(dir, 2))
        else $error("Pin enable does not follow direction");

    a_input_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
        (PIN_OUT & ~PIN_OE) == '0)
        else $error("Output level reaches an input pin");

    a_reset_values: assert property (@(posedge CLK) disable iff (SYS_RST)
        $past(SYS_RST) |-> out_lvl == {2{gpx_pkg::RST_ONES}}
            && invert == {2{gpx_pkg::RST_ZEROS}} && dir == {2{gpx_pkg::RST_ONES}}
            && mask == {2{gpx_pkg::RST_ONES}} && pull_sel == {2{gpx_pkg::RST_ONES}}
            && out_cfg == gpx_pkg::RST_ZEROS)
        else $error("Register reset value wrong");

    a_irq_flags: assert property (@(posedge CLK) disable iff (SYS_RST)
        rd_pulse && link_ptr == gpx_pkg::PTR_IRQ0 |=> rd_byte == gpx_pkg::IRQ_FLAGS_RST)
        else $error("Interrupt flag read not zero");

    a_pointer_load: assert property (@(posedge SCL) disable iff (link_rst)
        state == gpx_pkg::ST_CMD && bit_cnt == gpx_pkg::BIT_LAST
            |=> link_ptr == $past(rx_byte) && state == gpx_pkg::ST_WRITE)
        else $error("Command byte not loaded into pointer");

    a_ack_drive: assert property (@(negedge SCL) disable iff (link_rst)
        bit_cnt == gpx_pkg::BIT_ACK && ack_pending |=> SDA_OE)
        else $error("Acknowledge not driven");

endmodule // gpx_regmap

// [tb/gpx_master_model.sv]
// Purpose: Serial link master model for the expander's slave link
// Assumes: Open-drain data line with pull-up, resolved by the bench
// Notes: Clock stands high between frames; master never acks read bytes
`timescale 1ns/1ns
module gpx_master_model (
    // Link
    output logic SCL,
    output logic SDA_LOW,
    input wire logic SDA_LINE
);
    // Slow link: the register side needs several CLK edges per SCL phase
    localparam int Q = 50;

    initial begin
        SCL = 1'h1;
        SDA_LOW = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic start();
        SDA_LOW = 1'h0;
        #Q SCL = 1'h1;
        #Q SDA_LOW = 1'h1;
        #Q SCL = 1'h0;
        #Q;
    endtask

    task automatic stop();
        SDA_LOW = 1'h1;
        #Q SCL = 1'h1;
        #Q SDA_LOW = 1'h0;
        #Q;
    endtask

    // Eight bits out, ninth bit released and sampled
    task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic nak);
        for (int i = 8; i >= 0; i--) begin
            SDA_LOW = (i > 0) ? ~d[i-1] : 1'h0;
            #Q SCL = 1'h1;
            #Q;
            if (i > 0) r[i-1] = SDA_LINE;
            else nak = SDA_LINE;
            #Q SCL = 1'h0;
            #Q;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                      output logic nak);
        logic [7:0] r;
        logic n0, n1, n2;
        start();
        xbyte({a, 1'h0}, r, n0);
        xbyte(p, r, n1);
        xbyte(d, r, n2);
        stop();
        nak = n0 | n1 | n2;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
        logic [7:0] r;
        logic n;
        start();
        xbyte({a, 1'h0}, r, n);
        xbyte(p, r, n);
        start();
        xbyte({a, 1'h1}, r, n);
        xbyte(8'hFF, d, n);
        stop();
    endtask
endmodule // gpx_master_model

// [tb/gpx_regmap_tb_top.sv]
// Purpose: Self-checking bench for the expander register map
// Assumes: Register access only through the serial link model
// Notes: Link runs far slower than CLK, as the design requires
`timescale 1ns/1ns
module gpx_regmap_tb_top;
    localparam logic [6:0] DEV = {gpx_pkg::ADDR_HIGH_DEFAULT, 3'h5};
    localparam logic [15:0] RST_TAB [21] = '{16'h02FF, 16'h03FF, 16'h0400, 16'h0500,
        16'h06FF, 16'h07FF, 16'h40FF, 16'h41FF, 16'h42FF, 16'h43FF, 16'h4400, 16'h4500,
        16'h4600, 16'h4700, 16'h48FF, 16'h49FF, 16'h4AFF, 16'h4BFF, 16'h4C00, 16'h4D00,
        16'h4F00};
    localparam logic [7:0] RO_PTR [6] = '{8'h00, 8'h01, 8'h4C, 8'h4D, 8'h4E, 8'h08};
    localparam logic [15:0] PIN_TAB [7] = '{16'h0400, 16'h05FF, 16'h060F, 16'h07FF,
        16'h0255, 16'h4612, 16'h490F};
    // Clock starts high so reset rises as a real edge before the first rising edge
    logic clk = 1'h1;
    logic sys_rst = 1'h0;
    logic [2:0] addr_pin = 3'h5;
    logic [15:0] pin_in = 16'h3C5A;
    logic sda_out, sda_oe, scl, sda_low, sda_line, nak;
    logic [15:0] pin_out, pin_oe, pull_en, pull_up;
    int fail_count = 0;
    int cmp_count = 0;

    always #5 clk = ~clk;
    // Open-drain data line with pull-up
    assign sda_line = ~((sda_oe & ~sda_out) | sda_low);

    gpx_regmap dut_u (.CLK(clk), .SYS_RST(sys_rst), .SCL(scl), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_PIN(addr_pin), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULL_EN(pull_en), .PULL_UP(pull_up));
    gpx_master_model mst_u (.SCL(scl), .SDA_LOW(sda_low), .SDA_LINE(sda_line));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wreg(input logic [7:0] p, input logic [7:0] d);
        logic n;
        mst_u.wr(DEV, p, d, n);
        check("write ack", {15'h0000, n}, 16'h0000);
    endtask

    task automatic rreg(input logic [7:0] p, input logic [7:0] exp);
        logic [7:0] d;
        mst_u.rd(DEV, p, d);
        check($sformatf("register %h", p), {8'h00, d}, {8'h00, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #800000;
        fail_count++;
        end_of_test();
    end

    initial begin
        @(negedge clk) sys_rst = 1'h1;
        repeat (8) @(negedge clk);
        sys_rst = 1'h0;
        repeat (4) @(negedge clk);
        check("pin drive enable", pin_oe, 16'h0000);
        check("pull enable", pull_en, 16'h0000);
        check("pull select", pull_up, 16'hFFFF);
        foreach (RST_TAB[i]) rreg(RST_TAB[i][15:8], RST_TAB[i][7:0]);
        // Distinct pattern per writable register catches aliasing
        foreach (RST_TAB[i]) if (RST_TAB[i][15:9] != 7'h26) wreg(RST_TAB[i][15:8], 8'h5A ^ 8'(i));
        foreach (RST_TAB[i]) if (RST_TAB[i][15:9] != 7'h26) rreg(RST_TAB[i][15:8], 8'h5A ^ 8'(i));
        foreach (RO_PTR[i]) wreg(RO_PTR[i], 8'h77);
        rreg(8'h4C, 8'h00);
        rreg(8'h02, 8'h5A);
        rreg(8'h03, 8'h5B);
        rreg(8'h4E, gpx_pkg::UNMAPPED_READ);
        rreg(8'h08, gpx_pkg::UNMAPPED_READ);
        foreach (PIN_TAB[i]) wreg(PIN_TAB[i][15:8], PIN_TAB[i][7:0]);
        repeat (5) @(negedge clk);
        check("pin drive enable", pin_oe, 16'h00F0);
        check("pin level", pin_out, 16'h0050);
        check("pull enable", {8'h00, pull_en[7:0]}, 16'h0012);
        check("pull select", {8'h00, pull_up[15:8]}, 16'h000F);
        rreg(8'h00, 8'h5A);
        rreg(8'h01, 8'hC3);
        rreg(8'h02, 8'h55);
        @(negedge clk) pin_in = 16'hA5C3;
        rreg(8'h00, 8'hC3);
        rreg(8'h01, 8'h5A);
        mst_u.wr(DEV ^ 7'h01, 8'h02, 8'h00, nak);
        check("address refusal", {15'h0000, nak}, 16'h0001);
        rreg(8'h02, 8'h55);
        end_of_test();
    end
endmodule // gpx_regmap_tb_top
